// file: hw/lto_params.svh
// Constants for the literal and table-transfer decoder.
// Assumes inclusion by every file that decodes words or the register map.
`ifndef LTO_PARAMS_SVH
`define LTO_PARAMS_SVH

// Opcode fields of the one-word literal and table instructions and of the two-word pointer load
`define LTO_HI_ADD       8'h0F
`define LTO_HI_AND       8'h0B
`define LTO_HI_OR        8'h09
`define LTO_HI_XOR       8'h0A
`define LTO_HI_SUB       8'h08
`define LTO_HI_MOV       8'h0E
`define LTO_HI_MUL       8'h0D
`define LTO_HI_RET       8'h0C
`define LTO_HI_PTR       8'hEE
`define LTO_PTR_ZERO     2'h0
`define LTO_BANK_TOP     12'h010
`define LTO_TRD_TOP      14'h0002
`define LTO_TWR_TOP      14'h0003
`define LTO_OPND_NIB     4'hF

// Status flag positions
`define LTO_F_C          0
`define LTO_F_NWRAP      1
`define LTO_F_Z          2
`define LTO_F_SWRAP      3
`define LTO_F_N          4
`define LTO_MASK_ALL     5'h1F
`define LTO_MASK_ZN      5'h14
`define LTO_MASK_NONE    5'h00

// Register map, byte addresses
`define LTO_AW           8
`define LTO_OFF_ACC      8'h00
`define LTO_OFF_STATUS   8'h04
`define LTO_OFF_BANK     8'h08
`define LTO_OFF_CTRL     8'h0C
`define LTO_OFF_PROD     8'h10
`define LTO_RESP_OKAY    2'h0
`define LTO_RESP_SLVERR  2'h2

// Reset values
`define LTO_RST_BYTE     8'h00
`define LTO_RST_FLAGS    5'h00
`define LTO_RST_NIB      4'h0
`define LTO_RST_PROD     16'h0000
`define LTO_RST_WORD     16'h0000
`define LTO_RST_PTR      12'h000

`endif

// file: hw/lto_pkg.sv
// Types shared by the decoder and the executing core.
// Assumes nothing beyond a SystemVerilog compiler.
package lto_pkg;
	typedef enum logic [3:0] {
		op_nop,
		op_add_imm_to_acc,
		op_and_imm_into_acc,
		op_or_imm_into_acc,
		op_xor_imm_into_acc,
		op_imm_minus_acc,
		op_load_imm_to_acc,
		op_multiply_imm_by_acc,
		op_load_bank_selector,
		op_return_loading_imm,
		op_ptr_first,
		op_ptr_second,
		op_table_read_op,
		op_table_write_op
	} lto_op_t;

	typedef enum logic [1:0] {
		tbl_plain,
		tbl_post_inc,
		tbl_post_dec,
		tbl_pre_inc
	} lto_tbl_t;

	typedef enum logic [1:0] {
		ph_decode,
		ph_read,
		ph_process,
		ph_write
	} lto_phase_t;
endpackage

// file: hw/lto_dec_if.sv
// Carrier between the word decoder and the executing core.
// Assumes both ends share one clock; purely combinational signals.
`timescale 1ns/1ps
interface lto_dec_if;
	import lto_pkg::*;
	logic [15:0] ir;
	logic        is_operand;
	lto_op_t     op;
	logic [7:0]  lit;
	logic [1:0]  ptr_sel;
	lto_tbl_t    tbl_mode;
	logic        two_cycle;

	modport dec (input ir, input is_operand, output op, output lit, output ptr_sel,
		output tbl_mode, output two_cycle);
	modport exe (output ir, output is_operand, input op, input lit, input ptr_sel,
		input tbl_mode, input two_cycle);
endinterface

// file: hw/lto_decode.sv
// Combinational decoder of one held instruction word.
// Assumes the core holds the word and marks claimed operand words.
`timescale 1ns/1ps
`include "lto_params.svh"
module lto_decode (
	lto_dec_if.dec dif
);
	import lto_pkg::*;

	function automatic lto_op_t decode_word(input logic [15:0] w, input logic opnd);
		lto_op_t op;
		op = op_nop;
		if (opnd)
			op = op_ptr_second;
		else if (w[15:8] == `LTO_HI_ADD)
			op = op_add_imm_to_acc;
		else if (w[15:8] == `LTO_HI_AND)
			op = op_and_imm_into_acc;
		else if (w[15:8] == `LTO_HI_OR)
			op = op_or_imm_into_acc;
		else if (w[15:8] == `LTO_HI_XOR)
			op = op_xor_imm_into_acc;
		else if (w[15:8] == `LTO_HI_SUB)
			op = op_imm_minus_acc;
		else if (w[15:8] == `LTO_HI_MOV)
			op = op_load_imm_to_acc;
		else if (w[15:8] == `LTO_HI_MUL)
			op = op_multiply_imm_by_acc;
		else if (w[15:4] == `LTO_BANK_TOP)
			op = op_load_bank_selector;
		else if (w[15:8] == `LTO_HI_RET)
			op = op_return_loading_imm;
		else if (w[15:8] == `LTO_HI_PTR && w[7:6] == `LTO_PTR_ZERO)
			op = op_ptr_first;
		else if (w[15:2] == `LTO_TRD_TOP)
			op = op_table_read_op;
		else if (w[15:2] == `LTO_TWR_TOP)
			op = op_table_write_op;
		// Unclaimed second words and all other codes stay no-operation
		return op;
	endfunction

	assign dif.op        = decode_word(dif.ir, dif.is_operand);
	assign dif.lit       = dif.ir[7:0];
	assign dif.ptr_sel   = dif.ir[5:4];
	assign dif.tbl_mode  = lto_tbl_t'(dif.ir[1:0]);
	assign dif.two_cycle = (dif.op == op_return_loading_imm) || (dif.op == op_table_read_op)
		|| (dif.op == op_table_write_op);
endmodule

// file: hw/lto_literal_table_decoder.sv
// Literal and table-transfer instruction execute unit with register slave.
// Assumes one 100 MHz clock; four clocks form one instruction cycle.
//
// Behaviour
// - Add literal to accumulator, all five flags
// - AND literal into accumulator, Z and N
// - OR literal into accumulator, Z and N
// - XOR literal into accumulator, Z and N
// - Literal minus accumulator, all five flags
// - Load literal into accumulator, flags untouched
// - Multiply literal by accumulator, flags untouched
// - Four-bit literal into bank selector low bits
// - Load literal, return, two cycles, no flags
// - Two-word twelve-bit load into chosen pointer
// - Table reads with four pointer modes, two cycles
// - Table writes with four pointer modes, two cycles
// - Program-flow change costs a second no-op cycle
// - Unclaimed second word executes as no-operation
// - Port self-modify reads pins, not latch
// - Timer-zero self-modify clears assigned prescaler
//
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "lto_params.svh"
module lto_literal_table_decoder (
	input  logic                   ref_clk,
	input  logic                   rstn,
	input  logic [`LTO_AW-1:0]     s_axi_awaddr,
	input  logic                   s_axi_awvalid,
	output logic                   s_axi_awready,
	input  logic [31:0]            s_axi_wdata,
	input  logic [3:0]             s_axi_wstrb,
	input  logic                   s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  logic                   s_axi_bready,
	input  logic [`LTO_AW-1:0]     s_axi_araddr,
	input  logic                   s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  logic                   s_axi_rready,
	input  logic [15:0]            instr_word,
	input  logic                   instr_valid,
	output logic                   instr_ready,
	output logic [7:0]             working_accumulator,
	output logic [4:0]             status_flags,
	output logic [3:0]             data_bank_selector,
	output logic [15:0]            product,
	output logic                   ret_pop,
	output logic                   ptr_wr,
	output logic [1:0]             ptr_sel,
	output logic [11:0]            ptr_value,
	output logic                   tbl_req,
	output logic                   tbl_write,
	output lto_pkg::lto_tbl_t      tbl_step,
	input  logic                   rmw_req,
	input  logic                   rmw_on_port,
	input  logic                   rmw_on_timer0,
	input  logic                   rmw_dest_file,
	input  logic [7:0]             port_pins,
	input  logic [7:0]             file_data,
	output logic [7:0]             rmw_operand,
	output logic                   prescaler_clear
);
	import lto_pkg::*;

	function automatic logic reg_is(input logic [`LTO_AW-1:0] a, input logic [`LTO_AW-1:0] off);
		return a[`LTO_AW-1:2] == off[`LTO_AW-1:2];
	endfunction

	function automatic logic reg_mapped(input logic [`LTO_AW-1:0] a);
		return reg_is(a, `LTO_OFF_ACC) || reg_is(a, `LTO_OFF_STATUS) || reg_is(a, `LTO_OFF_BANK)
			|| reg_is(a, `LTO_OFF_CTRL) || reg_is(a, `LTO_OFF_PROD);
	endfunction

	lto_phase_t  phase_reg;
	lto_phase_t  phase_next;
	logic [15:0] ir_reg;
	logic        exec_valid_reg;
	logic        operand_reg;
	logic        ptr_pend_reg;
	logic        second_reg;
	logic [7:0]  lit_reg;
	logic [7:0]  res_reg;
	logic [4:0]  calc_reg;
	logic [7:0]  acc_reg;
	logic [7:0]  acc_next;
	logic [4:0]  flags_reg;
	logic [4:0]  flags_next;
	logic [3:0]  bank_reg;
	logic [3:0]  bank_next;
	logic [15:0] prod_reg;
	logic [3:0]  ptr_hi_reg;
	logic [1:0]  ptr_sel_hold_reg;
	logic        ctrl_presc_reg;
	logic        ctrl_presc_next;

	lto_dec_if dif ();
	assign dif.ir         = ir_reg;
	assign dif.is_operand = operand_reg;
	lto_decode u_dec (
		.dif (dif)
	);

	// Instruction cycle sequencing
	always_comb begin
		unique case (phase_reg)
			ph_decode:  phase_next = ph_read;
			ph_read:    phase_next = ph_process;
			ph_process: phase_next = ph_write;
			ph_write:   phase_next = ph_decode;
		endcase
	end

	wire take   = instr_ready && instr_valid;
	wire commit = (phase_reg == ph_write) && exec_valid_reg;
	assign instr_ready = (phase_reg == ph_decode) && !second_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			phase_reg      <= ph_decode;
			ir_reg         <= `LTO_RST_WORD;
			exec_valid_reg <= 1'b0;
			operand_reg    <= 1'b0;
			ptr_pend_reg   <= 1'b0;
			second_reg     <= 1'b0;
		end else begin
			phase_reg <= phase_next;
			if (phase_reg == ph_decode) begin
				exec_valid_reg <= take;
				operand_reg    <= take && ptr_pend_reg;
			end
			if (take) begin
				ir_reg       <= instr_word;
				ptr_pend_reg <= 1'b0;
			end else if (commit && dif.op == op_ptr_first) begin
				ptr_pend_reg <= 1'b1;
			end
			if (phase_reg == ph_write)
				second_reg <= commit && dif.two_cycle;
		end
	end

	// Arithmetic and logic on the held literal
	wire [8:0] add_full = {1'b0, acc_reg} + {1'b0, lit_reg};
	wire [4:0] add_low  = {1'b0, acc_reg[3:0]} + {1'b0, lit_reg[3:0]};
	wire [8:0] sub_full = {1'b0, lit_reg} + {1'b0, ~acc_reg} + 9'h001;
	wire [4:0] sub_low  = {1'b0, lit_reg[3:0]} + {1'b0, ~acc_reg[3:0]} + 5'h01;
	wire       is_add   = dif.op == op_add_imm_to_acc;
	wire       is_sub   = dif.op == op_imm_minus_acc;
	wire       is_logic = (dif.op == op_and_imm_into_acc) || (dif.op == op_or_imm_into_acc)
		|| (dif.op == op_xor_imm_into_acc);
	wire [7:0] alu_res  = is_add ? add_full[7:0] :
		is_sub ? sub_full[7:0] :
		(dif.op == op_and_imm_into_acc) ? (acc_reg & lit_reg) :
		(dif.op == op_or_imm_into_acc) ? (acc_reg | lit_reg) :
		(dif.op == op_xor_imm_into_acc) ? (acc_reg ^ lit_reg) :
		lit_reg;
	wire       wrap_add = (acc_reg[7] == lit_reg[7]) && (add_full[7] != acc_reg[7]);
	wire       wrap_sub = (lit_reg[7] != acc_reg[7]) && (sub_full[7] != lit_reg[7]);
	wire [4:0] alu_flag = {alu_res[7], is_sub ? wrap_sub : wrap_add, alu_res == `LTO_RST_BYTE,
		is_sub ? sub_low[4] : add_low[4], is_sub ? sub_full[8] : add_full[8]};
	wire [4:0] flag_mask = (is_add || is_sub) ? `LTO_MASK_ALL :
		is_logic ? `LTO_MASK_ZN : `LTO_MASK_NONE;
	wire       acc_wr   = commit && (is_add || is_sub || is_logic
		|| dif.op == op_load_imm_to_acc || dif.op == op_return_loading_imm);
	wire [15:0] prod_calc = acc_reg * lit_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			lit_reg  <= `LTO_RST_BYTE;
			res_reg  <= `LTO_RST_BYTE;
			calc_reg <= `LTO_RST_FLAGS;
		end else begin
			if (phase_reg == ph_read)
				lit_reg <= dif.lit;
			if (phase_reg == ph_process) begin
				res_reg  <= alu_res;
				calc_reg <= alu_flag;
			end
		end
	end

	// Register slave, one write and one read in flight
	logic             aw_held_reg;
	logic             w_held_reg;
	logic [`LTO_AW-1:0] aw_addr_reg;
	logic [7:0]       w_data_reg;
	logic             w_lane0_reg;
	logic             bvalid_reg;
	logic [1:0]       bresp_reg;
	logic             rvalid_reg;
	logic [31:0]      rdata_reg;
	logic [1:0]       rresp_reg;

	assign s_axi_awready = !aw_held_reg;
	assign s_axi_wready  = !w_held_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	wire do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	wire sw_wr    = do_write && w_lane0_reg;
	wire [31:0] rd_mux = reg_is(s_axi_araddr, `LTO_OFF_ACC) ? {24'h000000, acc_reg} :
		reg_is(s_axi_araddr, `LTO_OFF_STATUS) ? {27'h0000000, flags_reg} :
		reg_is(s_axi_araddr, `LTO_OFF_BANK) ? {28'h0000000, bank_reg} :
		reg_is(s_axi_araddr, `LTO_OFF_CTRL) ? {31'h00000000, ctrl_presc_reg} :
		reg_is(s_axi_araddr, `LTO_OFF_PROD) ? {16'h0000, prod_reg} : 32'h00000000;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= `LTO_OFF_ACC;
			w_data_reg  <= `LTO_RST_BYTE;
			w_lane0_reg <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `LTO_RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h00000000;
			rresp_reg   <= `LTO_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg  <= 1'b1;
				w_data_reg  <= s_axi_wdata[7:0];
				w_lane0_reg <= s_axi_wstrb[0];
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= reg_mapped(aw_addr_reg) ? `LTO_RESP_OKAY : `LTO_RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_mux;
				rresp_reg  <= reg_mapped(s_axi_araddr) ? `LTO_RESP_OKAY : `LTO_RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// Architectural state; an instruction commit outranks a software write
	assign acc_next = acc_wr ? res_reg :
		(sw_wr && reg_is(aw_addr_reg, `LTO_OFF_ACC)) ? w_data_reg : acc_reg;
	assign flags_next = commit ? ((flags_reg & ~flag_mask) | (calc_reg & flag_mask)) :
		(sw_wr && reg_is(aw_addr_reg, `LTO_OFF_STATUS)) ? w_data_reg[4:0] : flags_reg;
	assign bank_next = (commit && dif.op == op_load_bank_selector) ? lit_reg[3:0] :
		(sw_wr && reg_is(aw_addr_reg, `LTO_OFF_BANK)) ? w_data_reg[3:0] : bank_reg;
	assign ctrl_presc_next = (sw_wr && reg_is(aw_addr_reg, `LTO_OFF_CTRL)) ? w_data_reg[0] :
		ctrl_presc_reg;

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			acc_reg        <= `LTO_RST_BYTE;
			flags_reg      <= `LTO_RST_FLAGS;
			bank_reg       <= `LTO_RST_NIB;
			ctrl_presc_reg <= 1'b0;
			prod_reg       <= `LTO_RST_PROD;
		end else begin
			acc_reg        <= acc_next;
			flags_reg      <= flags_next;
			bank_reg       <= bank_next;
			ctrl_presc_reg <= ctrl_presc_next;
			if (commit && dif.op == op_multiply_imm_by_acc)
				prod_reg <= prod_calc;
		end
	end

	assign working_accumulator = acc_reg;
	assign status_flags        = flags_reg;
	assign data_bank_selector  = bank_reg;
	assign product             = prod_reg;

	// Strobes to the return stack, pointer file and table unit
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ret_pop          <= 1'b0;
			ptr_wr           <= 1'b0;
			ptr_sel          <= `LTO_PTR_ZERO;
			ptr_value        <= `LTO_RST_PTR;
			ptr_hi_reg       <= `LTO_RST_NIB;
			ptr_sel_hold_reg <= `LTO_PTR_ZERO;
			tbl_req          <= 1'b0;
			tbl_write        <= 1'b0;
			tbl_step         <= tbl_plain;
			rmw_operand      <= `LTO_RST_BYTE;
			prescaler_clear  <= 1'b0;
		end else begin
			ret_pop <= commit && dif.op == op_return_loading_imm;
			ptr_wr  <= commit && dif.op == op_ptr_second;
			tbl_req <= commit && (dif.op == op_table_read_op || dif.op == op_table_write_op);
			if (commit && dif.op == op_ptr_first) begin
				ptr_hi_reg       <= lit_reg[3:0];
				ptr_sel_hold_reg <= dif.ptr_sel;
			end
			if (commit && dif.op == op_ptr_second) begin
				ptr_value <= {ptr_hi_reg, lit_reg};
				ptr_sel   <= ptr_sel_hold_reg;
			end
			if (commit && (dif.op == op_table_read_op || dif.op == op_table_write_op)) begin
				tbl_write <= dif.op == op_table_write_op;
				tbl_step  <= dif.tbl_mode;
			end
			if (rmw_req)
				rmw_operand <= rmw_on_port ? port_pins : file_data;
			prescaler_clear <= rmw_req && rmw_on_timer0 && rmw_dest_file
				&& ctrl_presc_reg;
		end
	end

	default clocking dc @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);

	wire w_cmt = commit;

	a_add_sum: assert property (w_cmt && is_add |=>
		working_accumulator == 8'($past(acc_reg) + $past(lit_reg))) else $error("add result wrong");
	a_and_flags: assert property (w_cmt && dif.op == op_and_imm_into_acc |=>
		acc_reg == ($past(acc_reg) & $past(lit_reg)) && flags_reg[1:0] == $past(flags_reg[1:0])
		&& flags_reg[`LTO_F_SWRAP] == $past(flags_reg[`LTO_F_SWRAP])) else $error("and wrong");
	a_or_zero: assert property (w_cmt && dif.op == op_or_imm_into_acc |=>
		acc_reg == ($past(acc_reg) | $past(lit_reg))
		&& flags_reg[`LTO_F_Z] == (acc_reg == `LTO_RST_BYTE)) else $error("or wrong");
	a_xor_neg: assert property (w_cmt && dif.op == op_xor_imm_into_acc |=>
		acc_reg == ($past(acc_reg) ^ $past(lit_reg))
		&& flags_reg[`LTO_F_N] == acc_reg[7]) else $error("xor wrong");
	a_sub_diff: assert property (w_cmt && is_sub |=>
		acc_reg == 8'($past(lit_reg) - $past(acc_reg))
		&& flags_reg[`LTO_F_C] == ($past(lit_reg) >= $past(acc_reg))) else $error("subtract wrong");
	a_mov_still: assert property (w_cmt && dif.op == op_load_imm_to_acc |=>
		acc_reg == $past(lit_reg) && $stable(flags_reg)) else $error("load wrong");
	a_mul_prod: assert property (w_cmt && dif.op == op_multiply_imm_by_acc |=>
		prod_reg == $past(acc_reg) * $past(lit_reg) && $stable(flags_reg))
		else $error("multiply wrong");
	a_bank_load: assert property (w_cmt && dif.op == op_load_bank_selector |=>
		bank_reg == $past(ir_reg[3:0])) else $error("bank load wrong");
	a_ret_second: assert property (w_cmt && dif.op == op_return_loading_imm |=>
		(ret_pop && !instr_ready) ##1 (!instr_ready && !ret_pop) [*3])
		else $error("return not two cycles");
	a_ptr_join: assert property (w_cmt && dif.op == op_ptr_second |=>
		ptr_wr && ptr_value == {$past(ptr_hi_reg), $past(lit_reg)})
		else $error("pointer load wrong");
	a_tbl_mode: assert property (w_cmt && dif.op == op_table_read_op |=>
		tbl_req && !tbl_write && tbl_step == $past(ir_reg[1:0])) else $error("table read wrong");
	a_opnd_nop: assert property (phase_reg == ph_read && !operand_reg
		&& ir_reg[15:12] == `LTO_OPND_NIB |-> dif.op == op_nop) else $error("lone operand ran");
	a_rmw_pins: assert property (rmw_req && rmw_on_port |=>
		rmw_operand == $past(port_pins)) else $error("port operand not from pins");
	a_presc_clear: assert property (rmw_req && rmw_on_timer0 && rmw_dest_file
		&& ctrl_presc_reg |=> prescaler_clear) else $error("prescaler not cleared");
	a_phase_walk: assert property (phase_reg == ph_decode |=> phase_reg == ph_read
		##1 phase_reg == ph_process ##1 phase_reg == ph_write) else $error("phase order wrong");
endmodule

// file: dv/lto_prog_model.sv
// Program memory model that feeds instruction words to the decoder.
// Assumes the bench loads mem and len_reg by hierarchical reference.
`timescale 1ns/1ps
module lto_prog_model (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        instr_ready,
	output logic [15:0]      instr_word,
	output logic             instr_valid
);
	logic [15:0] mem [0:255];
	logic [7:0]  pc_reg;
	logic [7:0]  len_reg;
	assign instr_valid = pc_reg != len_reg;
	// Idle bus shows the inverse of the last word
	assign instr_word = instr_valid ? mem[pc_reg] : ~mem[pc_reg - 8'h01];
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			pc_reg <= 8'h00;
		end else if (instr_valid && instr_ready) begin
			pc_reg <= pc_reg + 8'h01;
		end
	end
endmodule

// file: dv/tb_literal_and_table_op_decoder.sv
// Self-checking bench for the literal and table-transfer execute unit.
// Assumes the design files and the program model compile first.
`timescale 1ns/1ps
`include "lto_params.svh"
module tb_literal_and_table_op_decoder;
	import lto_pkg::*;
	logic        ref_clk, rstn, rmw_req, rmw_on_port, rmw_on_timer0, rmw_dest_file;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, working_accumulator, port_pins, file_data;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]  s_axi_wstrb, data_bank_selector, e_bank;
	logic [1:0]  s_axi_bresp, s_axi_rresp, ptr_sel, rs;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, instr_valid, instr_ready, ret_pop;
	logic        ptr_wr, tbl_req, tbl_write, prescaler_clear;
	logic [15:0] instr_word, product, e_prod;
	logic [7:0]  rmw_operand, e_acc;
	logic [4:0]  status_flags, e_fl;
	logic [11:0] ptr_value, v;
	lto_tbl_t    tbl_step;
	int          n_mismatch, n_compared, cyc, i;
	logic [7:0]  ops [9] = '{8'h0F, 8'h0B, 8'h09, 8'h0A, 8'h08, 8'h0E, 8'h0D, 8'h0C, 8'h01};
	logic [15:0] cw [9] = '{16'h0E7F, 16'h0F01, 16'h0EFF, 16'h0F01, 16'h0800,
		16'h0E01, 16'h0800, 16'h0D80, 16'h010F};

	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end

	lto_prog_model pm_u (.ref_clk, .rstn, .instr_ready, .instr_word, .instr_valid);
	lto_literal_table_decoder dut_u (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.instr_word, .instr_valid, .instr_ready, .working_accumulator, .status_flags,
		.data_bank_selector, .product, .ret_pop, .ptr_wr, .ptr_sel, .ptr_value, .tbl_req,
		.tbl_write, .tbl_step, .rmw_req, .rmw_on_port, .rmw_on_timer0, .rmw_dest_file,
		.port_pins, .file_data, .rmw_operand, .prescaler_clear);

	task automatic give_verdict;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc > 30000) begin
			n_mismatch++;
			give_verdict();
		end
	end

	// Flags from bit 4 down: sign, signed wrap, zero, nibble wrap, carry
	function automatic logic [12:0] alu(input logic [7:0] hi, k, a, input logic [4:0] f);
		logic [8:0] r;
		r = {1'b0, a};
		case (hi)
			8'h0F: begin
				r = k + a;
				f = {r[7], a[7] == k[7] && r[7] != a[7], r[7:0] == 0,
					{1'b0, a[3:0]} + k[3:0] > 5'h0F, r[8]};
			end
			8'h08: begin
				r = k - a;
				f = {r[7], k[7] != a[7] && r[7] != k[7], r[7:0] == 0, k[3:0] >= a[3:0], k >= a};
			end
			8'h0B, 8'h09, 8'h0A: begin
				r = hi == 8'h0B ? k & a : hi == 8'h09 ? k | a : k ^ a;
				f = {r[7], f[3], r[7:0] == 0, f[1:0]};
			end
			8'h0E, 8'h0C: r = k;
			default: r = {1'b0, a};
		endcase
		return {f, r[7:0]};
	endfunction

	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		int t;
		tb = 0;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		for (t = 0; t < 40 && !tb; t++) begin
			@(negedge ref_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge ref_clk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			if (tb) s_axi_bready <= 0;
		end
		if (!tb) n_mismatch++;
	endtask

	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		int t;
		tr = 0;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		for (t = 0; t < 40 && !tr; t++) begin
			@(negedge ref_clk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge ref_clk);
			if (ta) s_axi_arvalid <= 0;
			if (tr) s_axi_rready <= 0;
		end
		if (!tr) n_mismatch++;
	endtask

	// Append one word, wait for its take, stop just after the write phase
	task automatic run(input logic [15:0] w);
		int t;
		t = 0;
		@(posedge ref_clk);
		pm_u.mem[pm_u.len_reg] <= w;
		pm_u.len_reg <= pm_u.len_reg + 8'h01;
		do begin
			@(posedge ref_clk);
			#1;
			t++;
		end while (pm_u.pc_reg != pm_u.len_reg && t < 20);
		if (t >= 20) n_mismatch++;
		repeat (2) @(posedge ref_clk);
		#1;
		chk("acc early", working_accumulator, e_acc);
		@(posedge ref_clk);
		#1;
	endtask

	task automatic lit(input logic [15:0] w);
		logic [12:0] r;
		r = alu(w[15:8], w[7:0], e_acc, e_fl);
		if (w[15:8] == 8'h0D) e_prod = w[7:0] * e_acc;
		if (w[15:4] == 12'h010) e_bank = w[3:0];
		run(w);
		{e_fl, e_acc} = r;
		chk("acc", working_accumulator, e_acc);
		chk("flags", status_flags, e_fl);
		chk("bank", data_bank_selector, e_bank);
		chk("prod", product, e_prod);
		chk("ret", ret_pop, w[15:8] == 8'h0C);
		chk("ready", instr_ready, w[15:8] != 8'h0C);
	endtask

	initial begin
		{rstn, rmw_req, rmw_on_port, rmw_on_timer0, rmw_dest_file, port_pins, file_data} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{e_acc, e_fl, e_bank, e_prod} = 0;
		pm_u.len_reg = 0;
		pm_u.mem[255] = 0;
		void'($urandom(194));
		repeat (12) @(posedge ref_clk);
		rstn <= 1;
		s_axi_wstrb <= 4'hF;
		for (i = 0; i < 6; i++) begin
			axr(8'(4 * i), rd, rs);
			chk("reset reg", rd, 0);
			chk("rresp", rs, i == 5 ? `LTO_RESP_SLVERR : `LTO_RESP_OKAY);
		end
		axw(8'h14, 32'h5A, rs);
		chk("unmapped bresp", rs, `LTO_RESP_SLVERR);
		axw(`LTO_OFF_ACC, 32'hA5, rs);
		e_acc = 8'hA5;
		axr(`LTO_OFF_ACC, rd, rs);
		chk("acc readback", rd, e_acc);
		$display("register bus done");
		foreach (cw[j]) lit(cw[j]);
		for (i = 0; i < 60; i++) begin
			v = 12'($urandom);
			rd[7:0] = ops[$urandom % 9];
			lit(rd[7:0] == 8'h01 ? {12'h010, v[3:0]} : {rd[7:0], v[7:0]});
		end
		$display("literal ops done");
		for (i = 0; i < 4; i++) begin
			v = 12'($urandom);
			run({8'hEE, 2'b00, 2'(i), v[11:8]});
			run({8'hF0, v[7:0]});
			chk("ptr_wr", ptr_wr, 1);
			chk("ptr_sel", ptr_sel, i[1:0]);
			chk("ptr_value", ptr_value, v);
		end
		run(16'hF0A5);
		chk("lone ptr_wr", ptr_wr, 0);
		chk("lone acc", working_accumulator, e_acc);
		for (i = 0; i < 8; i++) begin
			run(16'h0008 + 16'(i));
			chk("tbl_req", tbl_req, 1);
			chk("tbl_write", tbl_write, i[2]);
			chk("tbl_step", tbl_step, i[1:0]);
			chk("tbl ready", instr_ready, 0);
			chk("tbl flags", status_flags, e_fl);
		end
		$display("pointer and table done");
		for (i = 0; i < 16; i++) begin
			if (i % 8 == 0) axw(`LTO_OFF_CTRL, i / 8, rs);
			@(posedge ref_clk);
			{rmw_dest_file, rmw_on_timer0, rmw_on_port} <= 3'(i);
			{port_pins, file_data} <= 16'($urandom);
			rmw_req <= 1;
			@(posedge ref_clk);
			rmw_req <= 0;
			#1;
			chk("rmw", rmw_operand, i[0] ? port_pins : file_data);
			chk("prescale", prescaler_clear, i[1] && i[2] && i[3]);
		end
		$display("self-modify done");
		give_verdict();
	end
endmodule
